//--- sim/link_model.sv
// Link-layer stand-in: makes the link clock and paces transfers
`timescale 1ns/100ps
module link_model
(
    // Link clock and requests
    output logic       rx_sys_clock,
    output logic       enable_n,
    output logic [4:0] port_select
);
    initial
    begin
        rx_sys_clock = 1'b0;
        enable_n     = 1'b1;
        port_select  = 5'h1f;
        #37;
        forever #62.5 rx_sys_clock = ~rx_sys_clock;
    end
    // Select is inverted when idle, so the idle value looks valid only when sel was 5'h1c to 5'h1f
    task automatic xfer(input logic [4:0] sel, input int words);
        @(posedge rx_sys_clock);
        #1;
        enable_n    = 1'b0;
        port_select = sel;
        repeat (words) @(posedge rx_sys_clock);
        #1;
        enable_n    = 1'b1;
        port_select = ~sel;
    endtask
endmodule

//--- sim/rx_sys_port_props.sv
// Port-level assertions for the receive system port
`timescale 1ns/100ps
module rx_sys_port_props
(
    // Clocks and reset
    input wire logic       CLOCK,
    input wire logic       RESETN,
    input wire logic       RX_SYS_CLOCK,
    // Link side
    input wire logic       RX_ENABLE_N,
    input wire logic [15:0] RX_SYS_DATA_BUS,
    input wire logic       RX_SYS_PARITY,
    input wire logic [3:1] RX_PORT_AVAILABLE_DIRECT,
    input wire logic       RX_START_OF_TRANSFER,
    // Configuration and status
    input wire logic [1:0] MODE_SELECT,
    input wire logic       NARROW_BUS,
    input wire logic [3:0] PORT_CELL_READY,
    input wire logic [3:0] PORT_EOP_READY,
    input wire logic       TX_LINE_HIZ_CONTROL,
    input wire logic       TX_LINE_OUT_A_OE,
    input wire logic       TX_LINE_OUT_B_OE
);
    // Old wide words may stand on the bus after a switch, so only fresh words count
    property p_narrow_top;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN)
        NARROW_BUS && $past(NARROW_BUS, 4) && !$past(RX_ENABLE_N) |-> RX_SYS_DATA_BUS[15:8] == 8'h00;
    endproperty
    a_narrow_top: assert property (p_narrow_top) else $error("upper byte not low");
    property p_parity;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN) RX_SYS_PARITY == ~^RX_SYS_DATA_BUS;
    endproperty
    a_parity: assert property (p_parity) else $error("parity not odd");
    property p_hold;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN) RX_ENABLE_N |=> $stable(RX_SYS_DATA_BUS);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved without enable");
    property p_sot_enable;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN) RX_START_OF_TRANSFER |-> !$past(RX_ENABLE_N);
    endproperty
    a_sot_enable: assert property (p_sot_enable) else $error("start flag without transfer");
    property p_l3_avail;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN)
        (MODE_SELECT == rx_sys_pkg::MODE_SEL_PKT3) [*6] |-> RX_PORT_AVAILABLE_DIRECT == 3'h0;
    endproperty
    a_l3_avail: assert property (p_l3_avail) else $error("available high in level three");
    property p_cell_avail;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN)
        (MODE_SELECT == rx_sys_pkg::MODE_SEL_CELL && !PORT_CELL_READY[1]) [*6] |-> !RX_PORT_AVAILABLE_DIRECT[1];
    endproperty
    a_cell_avail: assert property (p_cell_avail) else $error("available without cell");
    property p_eop_avail;
        @(posedge RX_SYS_CLOCK) disable iff (!RESETN)
        (MODE_SELECT == rx_sys_pkg::MODE_SEL_PKT2 && PORT_EOP_READY[2]) [*6] |-> RX_PORT_AVAILABLE_DIRECT[2];
    endproperty
    a_eop_avail: assert property (p_eop_avail) else $error("end of packet not shown");
    property p_hiz;
        @(posedge CLOCK) disable iff (!RESETN)
        TX_LINE_HIZ_CONTROL [*5] |-> !TX_LINE_OUT_A_OE && !TX_LINE_OUT_B_OE;
    endproperty
    a_hiz: assert property (p_hiz) else $error("line driven while floated");
    c_sot: cover property (@(posedge RX_SYS_CLOCK) RX_START_OF_TRANSFER);
    c_avail: cover property (@(posedge RX_SYS_CLOCK) $rose(RX_PORT_AVAILABLE_DIRECT[1]));
    c_hiz: cover property (@(posedge CLOCK) $fell(TX_LINE_OUT_A_OE));
endmodule

bind rx_sys_port rx_sys_port_props i_rx_sys_port_props
(
    .CLOCK, .RESETN, .RX_SYS_CLOCK, .RX_ENABLE_N, .RX_SYS_DATA_BUS, .RX_SYS_PARITY,
    .RX_PORT_AVAILABLE_DIRECT, .RX_START_OF_TRANSFER, .MODE_SELECT, .NARROW_BUS,
    .PORT_CELL_READY, .PORT_EOP_READY, .TX_LINE_HIZ_CONTROL, .TX_LINE_OUT_A_OE, .TX_LINE_OUT_B_OE
);

//--- sim/rx_sys_port_test.sv
// Self-checking bench for the receive system port
`timescale 1ns/100ps
module rx_sys_port_test;
    logic        clock, resetn, link_clock, enable_n, parity, sot, narrow, hiz, oe_a, oe_b;
    logic [4:0]  port_select, sel_port;
    logic [15:0] data, word_count;
    logic [3:1]  avail;
    logic [1:0]  mode;
    logic [7:0]  level;
    logic [3:0]  cell_ready, eop_ready;
    logic [31:0] fill;
    int          fails = 0;
    int          total_checks = 0;
    int          sots = 0;

    link_model i_link_model (.rx_sys_clock(link_clock), .enable_n(enable_n),
        .port_select(port_select));
    rx_sys_port i_rx_sys_port (.CLOCK(clock), .RESETN(resetn), .RX_SYS_CLOCK(link_clock),
        .RX_PORT_SELECT(port_select), .RX_ENABLE_N(enable_n), .RX_SYS_DATA_BUS(data),
        .RX_SYS_PARITY(parity), .RX_PORT_AVAILABLE_DIRECT(avail), .RX_START_OF_TRANSFER(sot),
        .MODE_SELECT(mode), .NARROW_BUS(narrow), .ALMOST_EMPTY_LEVEL(level),
        .PORT_CELL_READY(cell_ready), .PORT_EOP_READY(eop_ready), .PORT_FILL_COUNT(fill),
        .TX_LINE_HIZ_CONTROL(hiz), .TX_LINE_OUT_A_OE(oe_a), .TX_LINE_OUT_B_OE(oe_b),
        .WORD_COUNT(word_count), .SELECTED_PORT(sel_port));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge link_clock)
        if (sot === 1'b1)
            sots++;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic links(input int n);
        repeat (n) @(posedge link_clock);
        #1;
    endtask
    task automatic status(input logic [1:0] m, input logic nb, input logic [3:0] cr,
        input logic [3:0] er, input logic [31:0] fc);
        @(negedge clock);
        mode       = m;
        narrow     = nb;
        cell_ready = cr;
        eop_ready  = er;
        fill       = fc;
        links(6);
    endtask
    task automatic t_cell;
        logic [15:0] w0;
        logic [15:0] d;
        status(rx_sys_pkg::MODE_SEL_CELL, 1'b0, 4'b0110, 4'hf, 32'h09030500);
        chk("available", 3'b001, avail);
        w0 = word_count;
        i_link_model.xfer(5'h02, 4);
        links(1);
        chk("word count", w0 + 16'h0004, word_count);
        chk("selected port", 5'h02, sel_port);
        i_link_model.xfer(5'h07, 1);
        links(1);
        chk("ignored select", 5'h02, sel_port);
        d = data;
        links(3);
        chk("held data", d, data);
        status(rx_sys_pkg::MODE_SEL_CELL, 1'b0, 4'b0100, 4'hf, 32'h09030500);
        chk("available no cell", 3'b000, avail);
        $display("cell mode test done");
    endtask
    task automatic t_pkt2;
        status(rx_sys_pkg::MODE_SEL_PKT2, 1'b1, 4'h0, 4'b0100, 32'h00000400);
        chk("available", 3'b011, avail);
        // Enough words to carry the running pattern past one byte
        i_link_model.xfer(5'h03, 256);
        chk("upper byte", 8'h00, data[15:8]);
        chk("narrow word", 16'h0004, data);
        chk("parity", 1'b0, parity);
        $display("level two narrow test done");
    endtask
    task automatic t_pkt3;
        status(rx_sys_pkg::MODE_SEL_PKT3, 1'b0, 4'hf, 4'hf, 32'hffffffff);
        chk("available", 3'b000, avail);
        sots = 0;
        i_link_model.xfer(5'h01, 3);
        links(2);
        chk("start flags", 1, sots);
        chk("wide word", 16'h0107, data);
        chk("level three select", 5'h03, sel_port);
        $display("level three test done");
    endtask
    task automatic t_hiz;
        @(negedge clock);
        hiz = 1'b1;
        repeat (6) @(negedge clock);
        chk("enables floated", 2'b00, {oe_a, oe_b});
        hiz = 1'b0;
        repeat (6) @(negedge clock);
        chk("enables driven", 2'b11, {oe_a, oe_b});
        $display("line float test done");
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        {resetn, narrow, hiz, mode, cell_ready, eop_ready, fill} = '0;
        level = 8'h03;
        repeat (5) @(posedge link_clock);
        #1;
        chk("reset outputs", {16'h0000, 1'b1, 3'h0, 1'b0}, {data, parity, avail, sot});
        chk("reset status", {16'h0000, 5'h1f, 2'b00}, {word_count, sel_port, oe_a, oe_b});
        @(negedge clock);
        resetn = 1'b1;
        links(3);
        t_cell;
        t_pkt2;
        t_pkt3;
        t_hiz;
        results;
    end
    // Whole run needs some forty microseconds
    initial
    begin
        #60000;
        fails++;
        results;
    end
endmodule

//--- src/port_status_if.sv
// Carries per-port status from the core domain to the link-side logic
`timescale 1ns/100ps
interface port_status_if;
    logic [rx_sys_pkg::PORTS-1:0]                       cell_ready;
    logic [rx_sys_pkg::PORTS-1:0]                       eop_ready;
    logic [rx_sys_pkg::PORTS*rx_sys_pkg::CNT_W-1:0]     fill_count;
    logic [rx_sys_pkg::CNT_W-1:0]                       almost_empty;
    modport source (output cell_ready, eop_ready, fill_count, almost_empty);
    modport sink   (input  cell_ready, eop_ready, fill_count, almost_empty);
endinterface

//--- src/rx_sys_pkg.sv
// Shared constants and types for the receive system port
package rx_sys_pkg;
    localparam int PORTS      = 4;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int ADDR_W     = 5;
    localparam int CNT_W      = 8;
    localparam int WORD_CNT_W = 16;
    localparam int FIRST_DIRECT_PORT = 1;
    localparam logic [ADDR_W-1:0] ADDR_NONE = 5'h1f;
    localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
    localparam logic              PAR_ODD   = 1'b1;
    // Interface modes
    typedef enum logic [2:0]
    {
        MODE_CELL = 3'b001,
        MODE_PKT2 = 3'b010,
        MODE_PKT3 = 3'b100
    } mode_e;
    localparam logic [1:0] MODE_SEL_CELL = 2'h0;
    localparam logic [1:0] MODE_SEL_PKT2 = 2'h1;
    localparam logic [1:0] MODE_SEL_PKT3 = 2'h2;
endpackage

//--- src/rx_sys_port.sv
// Receive system port: data bus, parity, port select and availability flags
// Function
// - All link signals timed on link clock rise
// - Wide bus: bit 15 most significant
// - Narrow bus: low byte used, top byte low
// - Parity output follows each data word
// - Packet level three ignores port select
// - Transfer only when enable sampled low
// - Cell mode: available with cell ready and above almost-empty cells
// - Packet two: available above level or end
// - Packet three: direct available held low
// - High hiz control floats transmit line outputs
// - Packet three: start flag with in-band address
`timescale 1ns/100ps
module rx_sys_port
(
    // Core clock and reset
    input  wire logic                                   CLOCK,
    input  wire logic                                   RESETN,
    // Link clock
    input  wire logic                                   RX_SYS_CLOCK,
    // Link inputs
    input  wire logic [rx_sys_pkg::ADDR_W-1:0]          RX_PORT_SELECT,
    input  wire logic                                   RX_ENABLE_N,
    // Link outputs
    output logic [rx_sys_pkg::DATA_W-1:0]               RX_SYS_DATA_BUS,
    output logic                                        RX_SYS_PARITY,
    output logic [rx_sys_pkg::PORTS-1:rx_sys_pkg::FIRST_DIRECT_PORT] RX_PORT_AVAILABLE_DIRECT,
    output logic                                        RX_START_OF_TRANSFER,
    // Configuration, core domain
    input  wire logic [1:0]                             MODE_SELECT,
    input  wire logic                                   NARROW_BUS,
    input  wire logic [rx_sys_pkg::CNT_W-1:0]           ALMOST_EMPTY_LEVEL,
    // Port status, core domain
    input  wire logic [rx_sys_pkg::PORTS-1:0]           PORT_CELL_READY,
    input  wire logic [rx_sys_pkg::PORTS-1:0]           PORT_EOP_READY,
    input  wire logic [rx_sys_pkg::PORTS*rx_sys_pkg::CNT_W-1:0] PORT_FILL_COUNT,
    // Transmit line control
    input  wire logic                                   TX_LINE_HIZ_CONTROL,
    output logic                                        TX_LINE_OUT_A_OE,
    output logic                                        TX_LINE_OUT_B_OE,
    // Transfer status, core domain
    output logic [rx_sys_pkg::WORD_CNT_W-1:0]           WORD_COUNT,
    output logic [rx_sys_pkg::ADDR_W-1:0]               SELECTED_PORT
);
    port_status_if status ();
    assign status.cell_ready   = PORT_CELL_READY;
    assign status.eop_ready    = PORT_EOP_READY;
    assign status.fill_count   = PORT_FILL_COUNT;
    assign status.almost_empty = ALMOST_EMPTY_LEVEL;

    logic                   link_resetn_meta;
    logic                   link_resetn;
    logic [1:0]             mode_meta;
    logic [1:0]             mode_sync;
    logic                   narrow_meta;
    logic                   narrow_sync;
    rx_sys_pkg::mode_e      mode;
    logic [rx_sys_pkg::PORTS-1:0] cell_ready;
    logic [rx_sys_pkg::PORTS-1:0] eop_ready;
    logic [rx_sys_pkg::PORTS-1:0] above_level;
    logic [rx_sys_pkg::ADDR_W-1:0] port_sel;
    logic [rx_sys_pkg::DATA_W-1:0] next_data;
    logic [rx_sys_pkg::DATA_W-1:0] word_source;
    logic                   pending_addr;
    logic                   xfer_toggle;
    logic [2:0]             toggle_sync;
    logic [1:0]             hiz_sync;

    function automatic logic odd_parity(input logic [rx_sys_pkg::DATA_W-1:0] w);
        return ~^w;
    endfunction

    // Reset release synchronised into the link domain
    always_ff @(posedge RX_SYS_CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            link_resetn_meta <= 1'b0;
            link_resetn      <= 1'b0;
        end
        else
        begin
            link_resetn_meta <= 1'b1;
            link_resetn      <= link_resetn_meta;
        end
    end

    // Quasi-static configuration crosses as levels
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
        begin
            mode_meta   <= rx_sys_pkg::MODE_SEL_CELL;
            mode_sync   <= rx_sys_pkg::MODE_SEL_CELL;
            narrow_meta <= 1'b0;
            narrow_sync <= 1'b0;
        end
        else
        begin
            mode_meta   <= MODE_SELECT;
            mode_sync   <= mode_meta;
            narrow_meta <= NARROW_BUS;
            narrow_sync <= narrow_meta;
        end
    end

    always_comb
    begin
        case (mode_sync)
            rx_sys_pkg::MODE_SEL_PKT2: mode = rx_sys_pkg::MODE_PKT2;
            rx_sys_pkg::MODE_SEL_PKT3: mode = rx_sys_pkg::MODE_PKT3;
            default:                   mode = rx_sys_pkg::MODE_CELL;
        endcase
    end

    status_sync u_status_sync
    (
        .clk         (RX_SYS_CLOCK),
        .resetn      (link_resetn),
        .src         (status),
        .cell_ready  (cell_ready),
        .eop_ready   (eop_ready),
        .above_level (above_level)
    );

    // Port selection; the select bus is sampled on the link clock
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
            port_sel <= rx_sys_pkg::ADDR_NONE;
        else if (mode != rx_sys_pkg::MODE_PKT3 && RX_PORT_SELECT < rx_sys_pkg::PORTS)
            port_sel <= RX_PORT_SELECT;
    end

    // Word source: a simple running pattern stands in for the port queue
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
            word_source <= rx_sys_pkg::DATA_IDLE;
        else if (!RX_ENABLE_N)
            word_source <= word_source + 16'h0001;
    end

    // Level three: the in-band address goes out first, once after each entry into level three
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
            pending_addr <= 1'b1;
        else if (mode != rx_sys_pkg::MODE_PKT3)
            pending_addr <= 1'b1;
        else if (!RX_ENABLE_N)
            pending_addr <= 1'b0;
    end

    always_comb
    begin
        if (mode == rx_sys_pkg::MODE_PKT3 && pending_addr)
            next_data = {{(rx_sys_pkg::DATA_W-rx_sys_pkg::ADDR_W){1'b0}}, port_sel};
        else
            next_data = word_source;
        if (narrow_sync)
            next_data[rx_sys_pkg::DATA_W-1:rx_sys_pkg::BYTE_W] = 8'h00;
    end

    // Data, parity and start flag registered on the link clock
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
        begin
            RX_SYS_DATA_BUS      <= rx_sys_pkg::DATA_IDLE;
            RX_SYS_PARITY        <= rx_sys_pkg::PAR_ODD;
            RX_START_OF_TRANSFER <= 1'b0;
        end
        else if (!RX_ENABLE_N)
        begin
            RX_SYS_DATA_BUS      <= next_data;
            RX_SYS_PARITY        <= odd_parity(next_data);
            RX_START_OF_TRANSFER <= mode == rx_sys_pkg::MODE_PKT3 && pending_addr;
        end
        else
        begin
            RX_SYS_PARITY        <= odd_parity(RX_SYS_DATA_BUS);
            RX_START_OF_TRANSFER <= 1'b0;
        end
    end

    // Direct availability flags for the upper ports
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
            RX_PORT_AVAILABLE_DIRECT <= '0;
        else
        begin
            for (int p = 2; p <= rx_sys_pkg::PORTS; p++)
            begin
                case (mode)
                    rx_sys_pkg::MODE_CELL:
                        RX_PORT_AVAILABLE_DIRECT[p-1] <= cell_ready[p-1] && above_level[p-1];
                    rx_sys_pkg::MODE_PKT2:
                        RX_PORT_AVAILABLE_DIRECT[p-1] <= above_level[p-1] || eop_ready[p-1];
                    default:
                        RX_PORT_AVAILABLE_DIRECT[p-1] <= 1'b0;
                endcase
            end
        end
    end

    // Transfer events cross to the core domain as a toggle
    always_ff @(posedge RX_SYS_CLOCK or negedge link_resetn)
    begin
        if (!link_resetn)
            xfer_toggle <= 1'b0;
        else if (!RX_ENABLE_N)
            xfer_toggle <= ~xfer_toggle;
    end

    // Counter misses events when transfers outpace the core sampling; core is much faster
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            toggle_sync <= 3'h0;
            WORD_COUNT  <= 16'h0000;
        end
        else
        begin
            toggle_sync <= {toggle_sync[1:0], xfer_toggle};
            if (toggle_sync[2] != toggle_sync[1])
                WORD_COUNT <= WORD_COUNT + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            SELECTED_PORT <= rx_sys_pkg::ADDR_NONE;
        else if (toggle_sync[2] != toggle_sync[1])
            SELECTED_PORT <= port_sel;
    end

    // Transmit line drivers float while the control pin is high
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            hiz_sync         <= 2'h3;
            TX_LINE_OUT_A_OE <= 1'b0;
            TX_LINE_OUT_B_OE <= 1'b0;
        end
        else
        begin
            hiz_sync         <= {hiz_sync[0], TX_LINE_HIZ_CONTROL};
            TX_LINE_OUT_A_OE <= ~hiz_sync[1];
            TX_LINE_OUT_B_OE <= ~hiz_sync[1];
        end
    end
endmodule

//--- src/status_sync.sv
// Brings the per-port status levels into the link clock domain
`timescale 1ns/100ps
module status_sync
(
    // Link clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // Core-domain status
    port_status_if.sink          src,
    // Synchronised status
    output logic [rx_sys_pkg::PORTS-1:0] cell_ready,
    output logic [rx_sys_pkg::PORTS-1:0] eop_ready,
    output logic [rx_sys_pkg::PORTS-1:0] above_level
);
    logic [rx_sys_pkg::PORTS-1:0] meta_cell;
    logic [rx_sys_pkg::PORTS-1:0] meta_eop;
    logic [rx_sys_pkg::PORTS-1:0] meta_above;
    logic [rx_sys_pkg::PORTS-1:0] raw_above;

    // Compare in the source domain so only single-bit levels cross
    always_comb
    begin
        for (int i = 0; i < rx_sys_pkg::PORTS; i++)
            raw_above[i] = src.fill_count[i*rx_sys_pkg::CNT_W +: rx_sys_pkg::CNT_W]
                           > src.almost_empty;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_cell   <= '0;
            meta_eop    <= '0;
            meta_above  <= '0;
            cell_ready  <= '0;
            eop_ready   <= '0;
            above_level <= '0;
        end
        else
        begin
            meta_cell   <= src.cell_ready;
            meta_eop    <= src.eop_ready;
            meta_above  <= raw_above;
            cell_ready  <= meta_cell;
            eop_ready   <= meta_eop;
            above_level <= meta_above;
        end
    end
endmodule
